// ### verilog/tcc_timer.sv
// Timer/counter top: prescaler, counter, task handling and APB register slave
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer (
	input  wire logic                clock_i,     // System clock, 40 MHz
	input  wire logic                rst_i,       // Synchronous reset, high
	input  wire logic                psel_i,      // APB select
	input  wire logic                penable_i,   // APB enable
	input  wire logic                pwrite_i,    // APB write
	input  wire logic [11:0]         paddr_i,     // APB byte address
	input  wire logic [31:0]         pwdata_i,    // APB write data
	output logic      [31:0]         prdata_o,    // APB read data
	output logic                     pready_o,    // APB ready
	output logic                     pslverr_o,   // APB error, unmapped address
	input  wire tcc_pkg::tcc_task_t  task_i,      // Task pulses from interconnect
	output logic      [3:0]          match_evt_o, // Match event pulses
	output logic                     irq_o,       // Enabled match flag pending
	output logic                     running_o    // Counter is started
);

	typedef struct packed {
		logic [5:0]  acc;      // Fractional 16 MHz generator
		logic [3:0]  sdiv;     // 1 MHz divider
		logic [11:0] pcnt;     // Prescaler counter
		logic        run;
		logic        mode;
		logic [1:0]  width;
		logic [3:0]  presc;
		logic [31:0] count;
		logic [3:0]  flags;
		logic [3:0]  shorts;
		logic [3:0]  inten;
		logic        pclr;     // Clear pending from a match shortcut
		logic [3:0]  evt;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} tcc_st_t;

	tcc_st_t s_q;
	tcc_st_t s_d;

	logic [31:0] cc [tcc_pkg::NSLOT];
	logic [3:0]  match;
	logic [3:0]  snap_wr;
	logic [3:0]  slot_wr;
	logic [31:0] mask;
	logic [31:0] next_cnt;
	logic        inc;
	logic        tick;
	logic        fast_en;
	logic        slow_en;
	logic        src_en;
	logic        use_slow;
	logic [3:0]  shift;
	logic [11:0] plast;
	logic        wr;
	logic        hit;
	logic [31:0] rdata;
	logic        t_start;
	logic        t_stop;
	logic        t_count;
	logic        t_clear;
	logic [3:0]  t_snap;

	// Bus write takes effect at the edge where the master sees pready
	assign wr = psel_i && penable_i && s_q.pready && pwrite_i && hit;

	// Address decode and read mux
	always_comb begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr_i)
			tcc_pkg::OFS_START,
			tcc_pkg::OFS_STOP,
			tcc_pkg::OFS_COUNT,
			tcc_pkg::OFS_CLEAR:  rdata = 32'h0000_0000;
			tcc_pkg::OFS_SHORTS: rdata = {28'h000_0000, s_q.shorts};
			tcc_pkg::OFS_INTEN:  rdata = {28'h000_0000, s_q.inten};
			tcc_pkg::OFS_MODE:   rdata = {31'h0000_0000, s_q.mode};
			tcc_pkg::OFS_WIDTH:  rdata = {30'h0000_0000, s_q.width};
			tcc_pkg::OFS_PRESC:  rdata = {28'h000_0000, s_q.presc};
			tcc_pkg::OFS_STATUS: rdata = {31'h0000_0000, s_q.run};
			tcc_pkg::OFS_VALUE:  rdata = s_q.count;
			default:             hit = 1'b0;
		endcase
		for (int i = 0; i < tcc_pkg::NSLOT; i++) begin
			if (paddr_i == tcc_pkg::OFS_SNAP0 + 12'(4 * i)) begin
				hit   = 1'b1;
				rdata = 32'h0000_0000;
			end
			if (paddr_i == tcc_pkg::OFS_MATCH0 + 12'(4 * i)) begin
				hit   = 1'b1;
				rdata = {31'h0000_0000, s_q.flags[i]};
			end
			if (paddr_i == tcc_pkg::OFS_SLOT0 + 12'(4 * i)) begin
				hit   = 1'b1;
				rdata = cc[i];
			end
		end
	end

	// Software task writes merge with interconnect task pulses
	always_comb begin
		for (int i = 0; i < tcc_pkg::NSLOT; i++) begin
			snap_wr[i] = wr && paddr_i == tcc_pkg::OFS_SNAP0 + 12'(4 * i) && pwdata_i[tcc_pkg::TRIG_BIT];
			slot_wr[i] = wr && paddr_i == tcc_pkg::OFS_SLOT0 + 12'(4 * i);
		end
	end
	assign t_start = task_i.start || (wr && paddr_i == tcc_pkg::OFS_START && pwdata_i[tcc_pkg::TRIG_BIT]);
	assign t_stop  = task_i.stop  || (wr && paddr_i == tcc_pkg::OFS_STOP  && pwdata_i[tcc_pkg::TRIG_BIT]);
	assign t_count = task_i.count || (wr && paddr_i == tcc_pkg::OFS_COUNT && pwdata_i[tcc_pkg::TRIG_BIT]);
	assign t_clear = task_i.clear || (wr && paddr_i == tcc_pkg::OFS_CLEAR && pwdata_i[tcc_pkg::TRIG_BIT]);
	assign t_snap  = task_i.snap | snap_wr;

	// 16 MHz enable from 40 MHz by fractional accumulation, 1 MHz by sixteen
	assign fast_en  = (s_q.acc + tcc_pkg::ACC_STEP) >= tcc_pkg::ACC_WRAP;
	assign slow_en  = fast_en && (s_q.sdiv == tcc_pkg::SLOW_LAST);
	// Slow source once the tick rate is 1 MHz or less, to save power
	assign use_slow = s_q.presc >= tcc_pkg::SLOW_SHIFT;
	assign src_en   = use_slow ? slow_en : fast_en;
	assign shift    = use_slow ? s_q.presc - tcc_pkg::SLOW_SHIFT : s_q.presc;
	// Divide by two to the prescaler; settings assumed stable while running
	assign plast    = 12'((32'h1 << shift) - 32'h1);
	// At or above the limit, so a phase left over from a larger prescaler cannot stall the tick
	assign tick     = s_q.run && src_en && (s_q.pcnt >= plast);

	// Timer mode counts ticks, counter mode counts tasks only
	assign inc = s_q.run && (s_q.mode == tcc_pkg::MODE_TIMER ? tick : t_count);

	// Masking the sum wraps past the width maximum to zero
	assign mask     = tcc_pkg::width_mask(s_q.width);
	assign next_cnt = (s_q.count + 32'h1) & mask;

	// Capture/compare slots
	for (genvar g = 0; g < tcc_pkg::NSLOT; g++) begin : g_slot
		tcc_slot u_slot (
			.clock_i (clock_i),
			.rst_i   (rst_i),
			.wr_i    (slot_wr[g]),
			.wdata_i (pwdata_i),
			.snap_i  (t_snap[g]),
			.cnt_i   (s_q.count),
			.next_i  (next_cnt),
			.inc_i   (inc && !(t_clear || s_q.pclr)),
			.mask_i  (mask),
			.cc_o    (cc[g]),
			.match_o (match[g])
		);
	end

	// Next state
	always_comb begin
		s_d         = s_q;
		s_d.evt     = 4'h0;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;

		// Rate generators run freely
		if (fast_en) begin
			s_d.acc  = s_q.acc + tcc_pkg::ACC_STEP - tcc_pkg::ACC_WRAP;
			s_d.sdiv = s_q.sdiv + 4'h1;
		end else begin
			s_d.acc = s_q.acc + tcc_pkg::ACC_STEP;
		end

		// Prescaler holds its phase while stopped
		if (s_q.run && src_en) begin
			s_d.pcnt = (s_q.pcnt >= plast) ? 12'h000 : s_q.pcnt + 12'h001;
		end

		// Stop wins over a simultaneous start; count is never touched here
		if (t_stop) begin
			s_d.run = 1'b0;
		end else if (t_start) begin
			s_d.run = 1'b1;
		end

		// Clear has priority over an increment in the same cycle
		if (t_clear || s_q.pclr) begin
			s_d.count = 32'h0000_0000;
		end else if (inc) begin
			s_d.count = next_cnt;
		end

		// Shortcut clears on the cycle after the match so the value is seen
		s_d.pclr = |(match & s_q.shorts);
		s_d.evt  = match;

		// Configuration writes
		if (wr) begin
			unique case (paddr_i)
				tcc_pkg::OFS_SHORTS: s_d.shorts = pwdata_i[3:0];
				tcc_pkg::OFS_INTEN:  s_d.inten  = pwdata_i[3:0];
				tcc_pkg::OFS_MODE:   s_d.mode   = pwdata_i[0];
				tcc_pkg::OFS_WIDTH:  s_d.width  = pwdata_i[1:0];
				tcc_pkg::OFS_PRESC:  s_d.presc  = pwdata_i[3:0];
				default:             s_d.mode   = s_d.mode;
			endcase
		end

		// Sticky flags: writing zero clears, a new match wins
		for (int i = 0; i < tcc_pkg::NSLOT; i++) begin
			if (wr && paddr_i == tcc_pkg::OFS_MATCH0 + 12'(4 * i) && !pwdata_i[0]) begin
				s_d.flags[i] = 1'b0;
			end
		end
		s_d.flags = s_d.flags | match;
		s_d.irq   = |(s_d.flags & s_d.inten);

		// Ready one cycle into the access phase
		if (psel_i && penable_i && !s_q.pready) begin
			s_d.pready  = 1'b1;
			s_d.prdata  = rdata;
			s_d.pslverr = !hit;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_q       <= '0;
			s_q.mode  <= tcc_pkg::RST_MODE;
			s_q.width <= tcc_pkg::RST_WIDTH;
			s_q.presc <= tcc_pkg::RST_PRESC;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state flops
	assign prdata_o    = s_q.prdata;
	assign pready_o    = s_q.pready;
	assign pslverr_o   = s_q.pslverr;
	assign match_evt_o = s_q.evt;
	assign irq_o       = s_q.irq;
	assign running_o   = s_q.run;

endmodule : tcc_timer
`default_nettype wire

// ### inc/tcc_pkg.sv
// Package: register map, field layout, resets, timing and carrier types for the timer/counter
// Summary of operation
// - Tick rate is 16 MHz over two-to-prescaler
// - At or below 1 MHz, use slow clock
// - Start task runs, stop task halts
// - Restart resumes from the held count
// - Timer mode adds one per tick
// - Counter mode adds one per increment task
// - Increment task ignored in timer mode
// - Counter width setting sets maximum value
// - Past maximum, wrap to zero, continue
// - Clear task forces count to zero
// - Snapshot task n copies count to slot
// - Match event when increment reaches slot value
// - Compare only bits within counter width
// - Clear, increment, stop act within one cycle
// - Stop beats start in same period
// - Resolution is one prescaled tick
// - Four slots with snapshot tasks and events
// - Per-slot option: match applies clear task
package tcc_pkg;

	// Clocking
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned FAST_HZ      = 16_000_000;
	localparam int unsigned SLOW_HZ      = 1_000_000;
	localparam int unsigned SLOW_DIV     = FAST_HZ / SLOW_HZ;
	localparam logic [5:0]  ACC_STEP     = 6'(FAST_HZ / 1_000_000);
	localparam logic [5:0]  ACC_WRAP     = 6'(CLK_HZ / 1_000_000);
	localparam logic [3:0]  SLOW_LAST    = 4'(SLOW_DIV - 1);
	localparam logic [3:0]  SLOW_SHIFT   = 4'h4;

	// Sizes
	localparam int unsigned NSLOT        = 4;
	localparam int unsigned AW           = 12;

	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_START    = 12'h000;
	localparam logic [11:0] OFS_STOP     = 12'h004;
	localparam logic [11:0] OFS_COUNT    = 12'h008;
	localparam logic [11:0] OFS_CLEAR    = 12'h00c;
	localparam logic [11:0] OFS_SNAP0    = 12'h040;
	localparam logic [11:0] OFS_MATCH0   = 12'h140;
	localparam logic [11:0] OFS_SHORTS   = 12'h200;
	localparam logic [11:0] OFS_INTEN    = 12'h300;
	localparam logic [11:0] OFS_MODE     = 12'h504;
	localparam logic [11:0] OFS_WIDTH    = 12'h508;
	localparam logic [11:0] OFS_PRESC    = 12'h510;
	localparam logic [11:0] OFS_SLOT0    = 12'h540;
	localparam logic [11:0] OFS_STATUS   = 12'h600;
	localparam logic [11:0] OFS_VALUE    = 12'h604;

	// Field positions and reset values
	localparam int unsigned TRIG_BIT     = 0;
	localparam int unsigned STAT_RUN_BIT = 0;
	localparam logic        MODE_TIMER   = 1'b0;
	localparam logic        MODE_COUNTER = 1'b1;
	localparam logic [1:0]  WIDTH_16     = 2'h0;
	localparam logic [1:0]  WIDTH_08     = 2'h1;
	localparam logic [1:0]  WIDTH_24     = 2'h2;
	localparam logic [1:0]  WIDTH_32     = 2'h3;
	localparam logic [1:0]  RST_WIDTH    = WIDTH_16;
	localparam logic [3:0]  RST_PRESC    = 4'h4;
	localparam logic        RST_MODE     = MODE_TIMER;

	// Task pulses from the event-task interconnect
	typedef struct packed {
		logic             start;
		logic             stop;
		logic             count;
		logic             clear;
		logic [NSLOT-1:0] snap;
	} tcc_task_t;

	// Mask of the active counter bits for a width setting
	function automatic logic [31:0] width_mask(input logic [1:0] sel);
		unique case (sel)
			WIDTH_08: width_mask = 32'h0000_00ff;
			WIDTH_24: width_mask = 32'h00ff_ffff;
			WIDTH_32: width_mask = 32'hffff_ffff;
			default:  width_mask = 32'h0000_ffff;
		endcase
	endfunction : width_mask

endpackage : tcc_pkg

// ### verilog/tcc_slot.sv
// One capture/compare slot: value storage, snapshot and masked match
`timescale 1ns/1ps
`default_nettype none
module tcc_slot (
	input  wire logic        clock_i,  // System clock
	input  wire logic        rst_i,    // Synchronous reset, high
	input  wire logic        wr_i,     // Software write strobe
	input  wire logic [31:0] wdata_i,  // Software write data
	input  wire logic        snap_i,   // Snapshot task pulse
	input  wire logic [31:0] cnt_i,    // Count before this edge
	input  wire logic [31:0] next_i,   // Count after this edge
	input  wire logic        inc_i,    // An increment happens now
	input  wire logic [31:0] mask_i,   // Active width mask
	output logic      [31:0] cc_o,     // Stored slot value
	output logic             match_o   // Match this cycle
);

	typedef struct packed {
		logic [31:0] cc;
	} tcc_slot_st_t;

	tcc_slot_st_t s_q;
	tcc_slot_st_t s_d;

	// Snapshot wins over a software write in the same cycle
	always_comb begin
		s_d = s_q;
		if (wr_i) begin
			s_d.cc = wdata_i;
		end
		if (snap_i) begin
			s_d.cc = cnt_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Only an increment can raise a match; upper bits are ignored
	assign match_o = inc_i && ((next_i & mask_i) == (s_q.cc & mask_i));
	assign cc_o    = s_q.cc;

endmodule : tcc_slot
`default_nettype wire

// ### sim/tcc_evt_src.sv
// Interconnect model that fires one-cycle task pulses into the timer
`timescale 1ns/1ps
`default_nettype none
module tcc_evt_src (
	input  wire logic              clock_i, // System clock
	output var tcc_pkg::tcc_task_t task_o   // Task pulses
);
	// One pulse per call, then an idle cycle so calls never collide
	task automatic fire(input logic [7:0] v);
		task_o <= tcc_pkg::tcc_task_t'(v);
		@(posedge clock_i);
		task_o <= '0;
		@(posedge clock_i);
	endtask : fire
	initial task_o = '0;
endmodule : tcc_evt_src
`default_nettype wire

// ### sim/tcc_timer_chk.sv
// Checker for task handling, match pulses and interrupt level
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_chk (
	input wire logic               clock_i,     // System clock
	input wire logic               rst_i,       // Reset
	input wire logic               psel_i,      // APB select
	input wire logic               pwrite_i,    // APB write
	input wire logic               pready_o,    // APB ready
	input wire tcc_pkg::tcc_task_t task_i,      // Task pulses
	input wire logic [3:0]         match_evt_o, // Match pulses
	input wire logic               irq_o,       // Interrupt
	input wire logic               running_o    // Started
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Start and stop show on the next edge; APB traffic excluded for the start and steady-state checks
	chk_start_runs: assert property (task_i.start && !task_i.stop && !psel_i |=> running_o)
		else $error("start did not run");
	chk_stop_halts: assert property (task_i.stop |=> !running_o)
		else $error("stop did not halt");
	chk_stop_wins: assert property (task_i.start && task_i.stop |=> !running_o)
		else $error("start beat stop");
	chk_run_steady: assert property (!task_i.start && !task_i.stop && !psel_i |=> $stable(running_o))
		else $error("run state moved alone");
	// A count cannot equal a slot twice in a row
	chk_match_once: assert property (|match_evt_o |=> !(|(match_evt_o & $past(match_evt_o))))
		else $error("match held two cycles");
	chk_match_running: assert property (|match_evt_o |-> $past(running_o))
		else $error("match while stopped");
	// Interrupt level moves only on a match or a register write
	chk_irq_rise: assert property ($rose(irq_o) |-> (|match_evt_o) || $past(|match_evt_o)
		|| $past(pready_o && pwrite_i) || $past(pready_o && pwrite_i, 2))
		else $error("irq rose without cause");
	chk_irq_fall: assert property ($fell(irq_o) |->
		$past(pready_o && pwrite_i) || $past(pready_o && pwrite_i, 2))
		else $error("irq fell without write");
endmodule : tcc_timer_chk
bind tcc_timer tcc_timer_chk i_chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .pwrite_i(pwrite_i),
	.pready_o(pready_o), .task_i(task_i), .match_evt_o(match_evt_o), .irq_o(irq_o), .running_o(running_o));
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench: APB register traffic and task pulses
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] T_GO  = 8'h80;
	localparam logic [7:0] T_END = 8'h40;
	localparam logic [7:0] T_INC = 8'h20;
	localparam logic [7:0] T_CLR = 8'h10;
	logic               clk, rst, psel, pen, pwr, pready, perr, irq, run, e;
	logic        [11:0] paddr;
	logic        [31:0] pwdata, prdata, r, x;
	logic         [3:0] mevt;
	tcc_pkg::tcc_task_t tsk;
	int                 fails, compares, i, p;
	int                 seen = 0;
	tcc_timer i_dut (.clock_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
		.task_i(tsk), .match_evt_o(mevt), .irq_o(irq), .running_o(run));
	tcc_evt_src i_src (.clock_i(clk), .task_o(tsk));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Slot 0 match pulses, counted mid-cycle so no check races the count
	always @(negedge clk) if (mevt[0]) seen++;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Request held until the edge that sees pready
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwr <= w;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk iff pready);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		cmp(r, x);
	endtask : rd
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// Tests take about 2400 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial begin
		fails = 0;
		compares = 0;
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(tcc_pkg::OFS_PRESC, 32'h4);
		rd(tcc_pkg::OFS_WIDTH, 32'h0);
		rd(12'hffc, 32'h0);
		cmp(32'(e), 32'h1);
		// Counter mode; settings change only while stopped
		apb(tcc_pkg::OFS_MODE, 1'b1, 32'h1);
		i_src.fire(T_GO);
		cmp(32'(run), 32'h1);
		repeat (5) i_src.fire(T_INC);
		i_src.fire(T_END);
		cmp(32'(run), 32'h0);
		i_src.fire(T_INC);
		rd(tcc_pkg::OFS_VALUE, 32'h5);
		i_src.fire(T_GO);
		i_src.fire(T_INC);
		rd(tcc_pkg::OFS_VALUE, 32'h6);
		// 8-bit width: upper slot bits ignored, then wrap
		i_src.fire(T_END);
		apb(tcc_pkg::OFS_WIDTH, 1'b1, 32'h1);
		apb(tcc_pkg::OFS_SLOT0, 1'b1, 32'h107);
		apb(tcc_pkg::OFS_INTEN, 1'b1, 32'h1);
		i_src.fire(T_GO);
		i_src.fire(T_INC);
		cmp(seen, 1);
		rd(tcc_pkg::OFS_MATCH0, 32'h1);
		cmp(32'(irq), 32'h1);
		apb(tcc_pkg::OFS_MATCH0, 1'b1, 32'h0);
		rd(tcc_pkg::OFS_MATCH0, 32'h0);
		cmp(32'(irq), 32'h0);
		repeat (248) i_src.fire(T_INC);
		rd(tcc_pkg::OFS_VALUE, 32'hff);
		i_src.fire(T_INC);
		rd(tcc_pkg::OFS_VALUE, 32'h0);
		i_src.fire(T_INC);
		i_src.fire(T_CLR);
		rd(tcc_pkg::OFS_VALUE, 32'h0);
		// Each snapshot takes the count into its own slot
		for (i = 0; i < 4; i++) begin
			i_src.fire(T_INC);
			i_src.fire(8'h01 << i);
			rd(tcc_pkg::OFS_SLOT0 + 12'(4 * i), 32'(i + 1));
		end
		// Match on slot 0 clears the count through the shortcut
		apb(tcc_pkg::OFS_SHORTS, 1'b1, 32'h1);
		i_src.fire(T_CLR);
		i_src.fire(T_INC);
		rd(tcc_pkg::OFS_VALUE, 32'h0);
		cmp(seen, 2);
		i_src.fire(T_GO | T_END);
		cmp(32'(run), 32'h0);
		// Timer mode: counts ignored, 800 cycles at two prescales
		apb(tcc_pkg::OFS_SHORTS, 1'b1, 32'h0);
		apb(tcc_pkg::OFS_MODE, 1'b1, 32'h0);
		apb(tcc_pkg::OFS_WIDTH, 1'b1, 32'h0);
		apb(tcc_pkg::OFS_PRESC, 1'b1, 32'hb);
		i_src.fire(T_CLR);
		i_src.fire(T_GO);
		repeat (3) i_src.fire(T_INC);
		i_src.fire(T_END);
		rd(tcc_pkg::OFS_VALUE, 32'h0);
		for (p = 0; p < 8; p += 4) begin
			apb(tcc_pkg::OFS_PRESC, 1'b1, 32'(p));
			i_src.fire(T_CLR);
			i_src.fire(T_GO);
			repeat (798) @(posedge clk);
			i_src.fire(T_END);
			apb(tcc_pkg::OFS_VALUE, 1'b0, 32'h0);
			x = 32'(320 >> p);
			cmp((r + 3 > x && r < x + 3) ? x : r, x);
		end
		cmp(seen, 4);
		// Wide widths: 24-bit ignores bit 24 of the slot, 32-bit does not
		apb(tcc_pkg::OFS_MODE, 1'b1, 32'h1);
		apb(tcc_pkg::OFS_SLOT0, 1'b1, 32'h0100_0002);
		for (p = 2; p < 4; p++) begin
			apb(tcc_pkg::OFS_WIDTH, 1'b1, 32'(p));
			i_src.fire(T_CLR);
			i_src.fire(T_GO);
			repeat (2) i_src.fire(T_INC);
			i_src.fire(T_END);
			rd(tcc_pkg::OFS_VALUE, 32'h2);
		end
		cmp(seen, 5);
		// Software task registers act like the interconnect pulses
		apb(tcc_pkg::OFS_START, 1'b1, 32'h1);
		rd(tcc_pkg::OFS_STATUS, 32'h1);
		apb(tcc_pkg::OFS_COUNT, 1'b1, 32'h1);
		apb(tcc_pkg::OFS_SNAP0 + 12'h00c, 1'b1, 32'h1);
		apb(tcc_pkg::OFS_STOP, 1'b1, 32'h1);
		rd(tcc_pkg::OFS_STATUS, 32'h0);
		rd(tcc_pkg::OFS_SLOT0 + 12'h00c, 32'h3);
		apb(tcc_pkg::OFS_CLEAR, 1'b1, 32'h1);
		rd(tcc_pkg::OFS_VALUE, 32'h0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
